/* verilog/port_a_defs.svh */
// constants for the six-bit parallel port: widths, register offsets, reset values
`ifndef PORT_A_DEFS_SVH
`define PORT_A_DEFS_SVH
`define PIN_COUNT        6
`define PIN_MSB          5
`define DIR_BITS         4
`define DIR_MSB          3
`define ADDR_MSB         7
`define OUTPUT_ONLY_MASK 6'h10
`define INPUT_CAP_MASK   6'h2F
`define ADDR_PIN_DATA    8'h00
`define ADDR_DIRECTION   8'h04
`define ADDR_DIGITAL_EN  8'h08
`define ADDR_ANALOG_EN   8'h0C
`define ADDR_DEBUG_EN    8'h10
`define ADDR_STATUS      8'h14
`define RST_PIN_DATA     6'h00
`define RST_DIRECTION    4'h0
`define RST_DIGITAL_EN   6'h00
`define RST_ANALOG_EN    6'h00
`define RST_DEBUG_EN     1'h1
`define RST_PIN_OUT      6'h00
`define RST_PIN_OE_B     6'h3F
`define RST_IBUF_EN      6'h2F
`define RST_PULL_EN      6'h00
`define RST_DRIVE_HIGH   6'h00
`define RST_WORD         32'h00000000
`define HTRANS_NONSEQ    2'h2
`define HRESP_OKAY       1'h0
`endif

/* verilog/port_a_pkg.sv */
// types shared by the port and its bus front end
package port_a_pkg;
`include "port_a_defs.svh"

  typedef enum logic [2:0] {
    PH_IDLE = 3'b001,
    PH_WAIT = 3'b010,
    PH_DONE = 3'b100
  } bus_phase_t;

  typedef struct packed {
    bus_phase_t             phase;
    logic [`ADDR_MSB:0]     addr;
    logic                   write;
    logic                   ready;
  } front_state_t;

  typedef struct packed {
    logic [`PIN_MSB:0]      pin_data;
    logic [`DIR_MSB:0]      direction;
    logic [`PIN_MSB:0]      digital_en;
    logic [`PIN_MSB:0]      analog_en;
    logic                   debug_en;
    logic [31:0]            hrdata;
    logic [`PIN_MSB:0]      pin_out;
    logic [`PIN_MSB:0]      pin_oe_b;
    logic [`PIN_MSB:0]      ibuf_en;
    logic [`PIN_MSB:0]      pull_en;
    logic [`PIN_MSB:0]      drive_high;
    logic                   hold;
  } port_state_t;
endpackage : port_a_pkg

/* verilog/pin_path_cell.sv */
// one pin's buffer steering and data-register read source
module pin_path_cell #(
  parameter bit OUTPUT_ONLY = 1'b0
) (
  input  wire logic dir_in,
  input  wire logic data_in,
  input  wire logic digital_en_in,
  input  wire logic alt_data_in,
  input  wire logic alt_drive_en_in,
  input  wire logic analog_en_in,
  input  wire logic pin_in,
  output logic      drive_out,
  output logic      oe_b_out,
  output logic      ibuf_en_out,
  output logic      read_bit_out
);
  // analog beats digital alternate, which beats the port itself
  always_comb begin
    drive_out = data_in;
    oe_b_out  = !(dir_in || OUTPUT_ONLY); // RULE4 RULE16
    if (analog_en_in) begin
      oe_b_out = 1'b1; // RULE7 RULE9
    end else if (digital_en_in) begin
      drive_out = alt_data_in; // RULE1 RULE6
      oe_b_out  = !alt_drive_en_in;
    end
  end

  // input buffer off for analog use and on the output-only pin
  assign ibuf_en_out  = !analog_en_in && !OUTPUT_ONLY; // RULE5 RULE7
  // direction picks the read source even under an alternate function
  assign read_bit_out = dir_in ? data_in : (ibuf_en_out && pin_in); // RULE4 RULE6 RULE8
endmodule : pin_path_cell

/* verilog/ahb_reg_front.sv */
// ahb-lite address/data phase tracking with one wait state per transfer
`include "port_a_defs.svh"
module ahb_reg_front
  import port_a_pkg::*;
(
  input  wire logic               clk_in,
  input  wire logic               rst_b_in,
  input  wire logic               hsel_in,
  input  wire logic [31:0]        haddr_in,
  input  wire logic [1:0]         htrans_in,
  input  wire logic               hwrite_in,
  input  wire logic               hready_in,
  output logic                    hreadyout_out,
  output logic                    wr_pulse_out,
  output logic                    rd_pulse_out,
  output logic [`ADDR_MSB:0]      addr_out
);
  front_state_t st;
  front_state_t next_st;
  logic         take;

  // the wait state lets a write land before the next read samples registers
  always_comb begin
    next_st = st;
    take    = hsel_in && hready_in && (htrans_in == `HTRANS_NONSEQ);
    case (st.phase)
      PH_WAIT: begin
        next_st.phase = PH_DONE;
      end
      PH_IDLE, PH_DONE: begin
        next_st.phase = take ? PH_WAIT : PH_IDLE;
      end
      default: begin
        next_st.phase = PH_IDLE;
      end
    endcase
    if (take && st.phase != PH_WAIT) begin
      next_st.addr  = haddr_in[`ADDR_MSB:0];
      next_st.write = hwrite_in;
    end
    next_st.ready = (next_st.phase != PH_WAIT);
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st <= '{phase: PH_IDLE, addr: '0, write: 1'b0, ready: 1'b1};
    end else begin
      st <= next_st;
    end
  end

  assign hreadyout_out = st.ready;
  assign wr_pulse_out  = (st.phase == PH_WAIT) && st.write;
  assign rd_pulse_out  = (st.phase == PH_WAIT) && !st.write;
  assign addr_out      = st.addr;
endmodule : ahb_reg_front

/* verilog/parallel_io_port_a.sv */
// six-bit parallel port with direction control, shared-function steering and ahb-lite registers
//
// Behaviour
// [RULE1] an enabled shared peripheral takes the pin from general I/O
// [RULE2] after reset shared functions off, pins inputs, pulls off, output-only pin is debug
// [RULE3] after reset every pin selects low drive strength
// [RULE4] direction bit enables the output buffer and picks the data read source
// [RULE5] input buffer always on except analog use or the output-only pin
// [RULE6] a shared digital function drives the buffer; direction still picks reads
// [RULE7] an analog function turns off both buffers of its pin
// [RULE8] input bit with its input buffer off reads zero
// [RULE9] analog beats digital alternate when both are enabled
// [RULE10] software should load data before turning a pin to output
// [RULE11] wait and stop hold every pin state; wakeup restores previous function
// [RULE12] an input bit reads the current pin level
// [RULE13] an output bit reads the value last written
// [RULE14] writes latch all data bits; output bits drive the latched level
// [RULE15] reset clears data to zero, and nothing is driven
// [RULE16] direction 0 means input and pin reads; 1 means output and latch reads
// [RULE17] top two data bits read zero; all data bits reset to zero (here only bit 4 reads zero; bit 5 reads its pin level as an input)
// [RULE18] unimplemented direction bits ignore writes and read zero
//
// Added by the designer: the placing of the registers and the AHB-Lite register port.
`include "port_a_defs.svh"
module parallel_io_port_a
  import port_a_pkg::*;
(
  input  wire logic               clk_in,
  input  wire logic               rst_b_in,
  input  wire logic               hsel_in,
  input  wire logic [31:0]        haddr_in,
  input  wire logic [1:0]         htrans_in,
  input  wire logic               hwrite_in,
  input  wire logic [2:0]         hsize_in,
  input  wire logic [31:0]        hwdata_in,
  input  wire logic               hready_in,
  output logic                    hreadyout_out,
  output logic [31:0]             hrdata_out,
  output logic                    hresp_out,
  input  wire logic [`PIN_MSB:0]  pin_in,
  output logic [`PIN_MSB:0]       pin_out,
  output logic [`PIN_MSB:0]       pin_oe_b_out,
  output logic [`PIN_MSB:0]       input_buffer_en_out,
  output logic [`PIN_MSB:0]       pull_device_enable_bit_out,
  output logic [`PIN_MSB:0]       drive_strength_select_bit_out,
  input  wire logic [`PIN_MSB:0]  alt_data_in,
  input  wire logic [`PIN_MSB:0]  alt_drive_en_in,
  input  wire logic               wait_mode_in,
  input  wire logic               stop_mode_in
);
  port_state_t          st;
  port_state_t          next_st;
  logic                 wr_pulse;
  logic                 rd_pulse;
  logic                 front_ready;
  logic [`ADDR_MSB:0]   addr;
  logic [`PIN_MSB:0]    dir_ext;
  logic [`PIN_MSB:0]    digital_eff;
  logic [`PIN_MSB:0]    cell_drive;
  logic [`PIN_MSB:0]    cell_oe_b;
  logic [`PIN_MSB:0]    cell_ibuf;
  logic [`PIN_MSB:0]    cell_read;
  logic                 low_power;
  localparam logic [`PIN_MSB:0] ONLY_PIN_MASK = `OUTPUT_ONLY_MASK;

  //////////////////////////////////////////////////////////////////////////////
  // bus front end

  // hsize is not decoded: only whole-word transfers are issued on this bus
  ahb_reg_front u_front (
    .clk_in        (clk_in),
    .rst_b_in      (rst_b_in),
    .hsel_in       (hsel_in),
    .haddr_in      (haddr_in),
    .htrans_in     (htrans_in),
    .hwrite_in     (hwrite_in),
    .hready_in     (hready_in),
    .hreadyout_out (front_ready),
    .wr_pulse_out  (wr_pulse),
    .rd_pulse_out  (rd_pulse),
    .addr_out      (addr)
  );

  //////////////////////////////////////////////////////////////////////////////
  // per-pin steering

  // pins above the direction field have no direction bit: pin 5 acts as an input, output-only pin 4 drives
  assign dir_ext     = {{(`PIN_COUNT - `DIR_BITS){1'b0}}, st.direction}; // RULE18
  // the debug function sits on the output-only pin as its shared function
  assign digital_eff = st.digital_en | ({`PIN_COUNT{st.debug_en}} & `OUTPUT_ONLY_MASK); // RULE2
  assign low_power   = wait_mode_in || stop_mode_in;

  // one cell per pin; the output-only pin gets its own flavour
  genvar gi;
  generate
    for (gi = 0; gi < `PIN_COUNT; gi++) begin : g_pin
      pin_path_cell #(
        .OUTPUT_ONLY (ONLY_PIN_MASK[gi])
      ) u_cell (
        .dir_in          (dir_ext[gi]),
        .data_in         (st.pin_data[gi]),
        .digital_en_in   (digital_eff[gi]),
        .alt_data_in     (alt_data_in[gi]),
        .alt_drive_en_in (alt_drive_en_in[gi]),
        .analog_en_in    (st.analog_en[gi]),
        .pin_in          (pin_in[gi]),
        .drive_out       (cell_drive[gi]),
        .oe_b_out        (cell_oe_b[gi]),
        .ibuf_en_out     (cell_ibuf[gi]),
        .read_bit_out    (cell_read[gi])
      );
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // register file and pin state

  always_comb begin
    next_st = st;
    // register writes land in the wait cycle of the data phase
    if (wr_pulse) begin
      case (addr)
        `ADDR_PIN_DATA: begin
          next_st.pin_data = hwdata_in[`PIN_MSB:0]; // RULE14
        end
        `ADDR_DIRECTION: begin
          next_st.direction = hwdata_in[`DIR_MSB:0]; // RULE16
        end
        `ADDR_DIGITAL_EN: begin
          next_st.digital_en = hwdata_in[`PIN_MSB:0]; // RULE1
        end
        `ADDR_ANALOG_EN: begin
          next_st.analog_en = hwdata_in[`PIN_MSB:0]; // RULE7
        end
        `ADDR_DEBUG_EN: begin
          next_st.debug_en = hwdata_in[0];
        end
        default: begin
          next_st.debug_en = st.debug_en;
        end
      endcase
    end
    // read word is built in the wait cycle, so it sees a just-finished write
    if (rd_pulse) begin
      case (addr)
        `ADDR_PIN_DATA: begin
          next_st.hrdata = {{(32 - `PIN_COUNT){1'b0}}, cell_read}; // RULE12 RULE13 RULE17
        end
        `ADDR_DIRECTION: begin
          next_st.hrdata = {{(32 - `DIR_BITS){1'b0}}, st.direction}; // RULE18
        end
        `ADDR_DIGITAL_EN: begin
          next_st.hrdata = {{(32 - `PIN_COUNT){1'b0}}, st.digital_en};
        end
        `ADDR_ANALOG_EN: begin
          next_st.hrdata = {{(32 - `PIN_COUNT){1'b0}}, st.analog_en};
        end
        `ADDR_DEBUG_EN: begin
          next_st.hrdata = {31'h00000000, st.debug_en};
        end
        `ADDR_STATUS: begin
          next_st.hrdata = {31'h00000000, st.hold};
        end
        default: begin
          next_st.hrdata = `RST_WORD;
        end
      endcase
    end
    // pins freeze in wait and stop; registers keep steering so wakeup restores them
    next_st.hold = low_power; // RULE11
    if (!low_power) begin
      next_st.pin_out  = cell_drive; // RULE6 RULE14
      next_st.pin_oe_b = cell_oe_b;  // RULE4 RULE7 RULE9
      next_st.ibuf_en  = cell_ibuf;  // RULE5
    end
    // pull and drive-strength controls live elsewhere; this port keeps them at default
    next_st.pull_en    = `RST_PULL_EN;    // RULE2
    next_st.drive_high = `RST_DRIVE_HIGH; // RULE3
  end

  // every control flop resets to a constant; pins come up undriven
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st.pin_data   <= `RST_PIN_DATA;   // RULE15 RULE17
      st.direction  <= `RST_DIRECTION;  // RULE2
      st.digital_en <= `RST_DIGITAL_EN; // RULE2
      st.analog_en  <= `RST_ANALOG_EN;
      st.debug_en   <= `RST_DEBUG_EN;   // RULE2
      st.hrdata     <= `RST_WORD;
      st.pin_out    <= `RST_PIN_OUT;
      st.pin_oe_b   <= `RST_PIN_OE_B;   // RULE15
      st.ibuf_en    <= `RST_IBUF_EN;
      st.pull_en    <= `RST_PULL_EN;
      st.drive_high <= `RST_DRIVE_HIGH; // RULE3
      st.hold       <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs

  assign hreadyout_out                 = front_ready;
  assign hrdata_out                    = st.hrdata;
  assign hresp_out                     = `HRESP_OKAY;
  assign pin_out                       = st.pin_out;
  assign pin_oe_b_out                  = st.pin_oe_b;
  assign input_buffer_en_out           = st.ibuf_en;
  assign pull_device_enable_bit_out    = st.pull_en;
  assign drive_strength_select_bit_out = st.drive_high;

  //////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);

  logic [`PIN_MSB:0] gpio_mask;
  logic              take_req;
  assign gpio_mask = ~digital_eff & ~st.analog_en;
  assign take_req  = hsel_in && hready_in && (htrans_in == `HTRANS_NONSEQ) && front_ready;

  // analog use leaves neither buffer on, whatever the alternate function asks
  a_analog_buffers_off: assert property ( // RULE7 RULE9
    (!low_power && |st.analog_en) |=>
      (((pin_oe_b_out & $past(st.analog_en)) == $past(st.analog_en)) &&
       ((input_buffer_en_out & $past(st.analog_en)) == '0)))
    else $error("analog pin still has a buffer enabled");

  a_alt_drives_pin: assert property ( // RULE1 RULE6
    (!low_power && |(digital_eff & ~st.analog_en)) |=>
      ((pin_out & $past(digital_eff & ~st.analog_en)) ==
       ($past(alt_data_in) & $past(digital_eff & ~st.analog_en))))
    else $error("shared digital function not driving its pin");

  a_gpio_output_drives: assert property ( // RULE4 RULE14
    (!low_power && |(gpio_mask & dir_ext)) |=>
      (((pin_oe_b_out & $past(gpio_mask & dir_ext)) == '0) &&
       ((pin_out & $past(gpio_mask & dir_ext)) == ($past(st.pin_data) & $past(gpio_mask & dir_ext)))))
    else $error("output pin not driving latched data");

  a_gpio_input_floats: assert property ( // RULE16
    (!low_power && |(gpio_mask & ~dir_ext & ~`OUTPUT_ONLY_MASK)) |=>
      ((pin_oe_b_out & $past(gpio_mask & ~dir_ext & ~`OUTPUT_ONLY_MASK)) ==
       $past(gpio_mask & ~dir_ext & ~`OUTPUT_ONLY_MASK)))
    else $error("input pin is driven");

  a_input_buffer_on: assert property ( // RULE5
    !low_power |=> ((input_buffer_en_out & `INPUT_CAP_MASK) == ($past(~st.analog_en) & `INPUT_CAP_MASK)) &&
                   ((input_buffer_en_out & `OUTPUT_ONLY_MASK) == '0))
    else $error("input buffer enable wrong");

  a_read_latched_bits: assert property ( // RULE13
    (rd_pulse && addr == `ADDR_PIN_DATA) |=>
      (((hrdata_out[`PIN_MSB:0] & $past(dir_ext)) == ($past(st.pin_data) & $past(dir_ext))) && hreadyout_out))
    else $error("output bit read is not the latched value");

  a_read_pin_bits: assert property ( // RULE12 RULE8
    (rd_pulse && addr == `ADDR_PIN_DATA) |=>
      ((hrdata_out[`PIN_MSB:0] & ~$past(dir_ext)) ==
       ($past(pin_in & ~st.analog_en) & ~`OUTPUT_ONLY_MASK & ~$past(dir_ext))))
    else $error("input bit read is not the pin level");

  a_data_upper_zero: assert property ( // RULE17
    (rd_pulse && addr == `ADDR_PIN_DATA) |=> (hrdata_out[31:`PIN_COUNT] == '0))
    else $error("unimplemented data bits not zero");

  a_dir_upper_zero: assert property ( // RULE18
    (rd_pulse && addr == `ADDR_DIRECTION) |=> (hrdata_out[31:`DIR_BITS] == '0))
    else $error("unimplemented direction bits not zero");

  a_hold_in_sleep: assert property ( // RULE11
    low_power |=> ($stable(pin_out) && $stable(pin_oe_b_out) && $stable(input_buffer_en_out)))
    else $error("pin state moved in low-power mode");

  a_default_drive: assert property ( // RULE3 RULE2
    (drive_strength_select_bit_out == '0) && (pull_device_enable_bit_out == '0))
    else $error("pull or drive strength not at default");

  a_reset_values: assert property ( // RULE15 RULE2
    $rose(rst_b_in) |-> ((st.pin_data == '0) && (st.direction == '0) && (pin_oe_b_out == `RST_PIN_OE_B)))
    else $error("port not at reset state after release");

  a_one_wait_state: assert property (
    take_req |=> !hreadyout_out ##1 hreadyout_out)
    else $error("bus answer not one wait state");

  // register writes land at the end of the wait cycle, whatever the pin state
  a_data_write_lands: assert property ( // RULE14
    (wr_pulse && addr == `ADDR_PIN_DATA) |=> (st.pin_data == $past(hwdata_in[`PIN_MSB:0])))
    else $error("data write did not land");

  // only the implemented direction bits take the write
  a_dir_write_lands: assert property ( // RULE16 RULE18
    (wr_pulse && addr == `ADDR_DIRECTION) |=> (st.direction == $past(hwdata_in[`DIR_MSB:0])))
    else $error("direction write did not land");

  // read word must stand until the next read, or a slow master loses it
  a_read_word_stands: assert property (
    !rd_pulse |=> $stable(hrdata_out))
    else $error("read word changed without a read");

  // offsets past the map read as an all-zero word
  a_unmapped_reads_zero: assert property (
    (rd_pulse && addr > `ADDR_STATUS) |=> (hrdata_out == `RST_WORD))
    else $error("unmapped offset read not zero");

  // the output-only pin has no input buffer, so its data bit reads zero
  a_only_pin_zero: assert property ( // RULE5 RULE8
    (rd_pulse && addr == `ADDR_PIN_DATA) |=> ((hrdata_out[`PIN_MSB:0] & `OUTPUT_ONLY_MASK) == '0))
    else $error("output-only pin data bit not zero");

  // status lags the low-power request by one cycle
  a_hold_status: assert property ( // RULE11
    low_power |=> st.hold)
    else $error("hold status not set in low-power mode");

  // software sees the held state through the status word
  a_status_read: assert property ( // RULE11
    (rd_pulse && addr == `ADDR_STATUS) |=> (hrdata_out == {31'h00000000, $past(st.hold)}))
    else $error("status read does not show hold");

  // while debug owns the output-only pin, its enable follows the debug function
  a_debug_owns_pin: assert property ( // RULE2
    (!low_power && st.debug_en && ((st.analog_en & `OUTPUT_ONLY_MASK) == '0)) |=>
      ((pin_oe_b_out & `OUTPUT_ONLY_MASK) == ($past(~alt_drive_en_in) & `OUTPUT_ONLY_MASK)))
    else $error("debug function does not own the output-only pin");

  // released by every shared function, the output-only pin drives port data
  a_released_pin_drives: assert property ( // RULE14
    (!low_power && (((digital_eff | st.analog_en) & `OUTPUT_ONLY_MASK) == '0)) |=>
      (((pin_oe_b_out & `OUTPUT_ONLY_MASK) == '0) &&
       ((pin_out & `OUTPUT_ONLY_MASK) == ($past(st.pin_data) & `OUTPUT_ONLY_MASK))))
    else $error("released output-only pin not driving port data");

  c_write_then_read: cover property (
    (wr_pulse && addr == `ADDR_PIN_DATA) ##[1:4] (rd_pulse && addr == `ADDR_PIN_DATA));

  c_analog_over_alt: cover property (
    |(st.analog_en & digital_eff));

  c_sleep_and_wake: cover property (
    !low_power ##1 low_power [*2] ##1 !low_power);

  c_output_driven: cover property (
    |(~pin_oe_b_out & ~`OUTPUT_ONLY_MASK));

  // debug released and the output-only pin driving port data
  c_debug_released: cover property (
    !st.debug_en ##1 ((~pin_oe_b_out & `OUTPUT_ONLY_MASK) != '0));
endmodule : parallel_io_port_a

/* sim/board_model.sv */
// board circuitry on the port pins: switches that lose to the chip wherever it drives
module board_model (
  input  wire logic [5:0] drv_level_in,
  input  wire logic [5:0] drv_oe_b_in,
  input  wire logic [5:0] ext_level_in,
  output logic      [5:0] pin_level_out
);
  timeunit 1ns;
  timeprecision 100ps;
  ////////////////////////////////////////////////////////////////////////////////
  // wire level per pin: a driving chip wins, otherwise the board switch sets it
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      pin_level_out[i] = (drv_oe_b_in[i] === 1'b0) ? drv_level_in[i] : ext_level_in[i];
    end
  end
endmodule : board_model

/* sim/parallel_io_port_a_tb.sv */
// self-checking bench for the six-bit port: bus tasks, random pin traffic, shared-function corners
module parallel_io_port_a_tb
  import port_a_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_in = 1'b0, rst_b_in = 1'b0, hsel = 1'b0, hwrite = 1'b0, wait_mode = 1'b0, stop_mode = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
  logic [1:0]  htrans = 2'h0;
  logic [5:0]  ext = 6'h00, alt_data = 6'h00, alt_drv = 6'h00, pin_lvl, pin_o, oe_b, ibuf, pull, drv, held;
  logic        hreadyout, hresp;
  logic [31:0] hrdata;
  logic [7:0]  seed = 8'h56;
  logic [5:0]  d;
  logic [3:0]  dir;
  int n_errors = 0;
  int checked = 0;

  always #20 clk_in = ~clk_in;

  parallel_io_port_a dut (.clk_in(clk_in), .rst_b_in(rst_b_in), .hsel_in(hsel), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hreadyout),
    .hreadyout_out(hreadyout), .hrdata_out(hrdata), .hresp_out(hresp), .pin_in(pin_lvl), .pin_out(pin_o),
    .pin_oe_b_out(oe_b), .input_buffer_en_out(ibuf), .pull_device_enable_bit_out(pull),
    .drive_strength_select_bit_out(drv), .alt_data_in(alt_data), .alt_drive_en_in(alt_drv),
    .wait_mode_in(wait_mode), .stop_mode_in(stop_mode));

  board_model board (.drv_level_in(pin_o), .drv_oe_b_in(oe_b), .ext_level_in(ext), .pin_level_out(pin_lvl));

  ////////////////////////////////////////////////////////////////////////////////
  // bench helpers
  function automatic logic [7:0] next_rand(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : next_rand

  // read value of the data register when no shared function is on
  function automatic logic [31:0] exp_read(input logic [5:0] data, input logic [3:0] dr, input logic [5:0] lv);
    logic [5:0] r;
    r = {lv[5], 1'b0, (dr & data[3:0]) | (~dr & lv[3:0])};
    return {26'h0, r};
  endfunction : exp_read

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // sample just before each rising edge, so the value seen is the one that edge takes
  task automatic wait_ready(output logic [31:0] data);
    logic rdy;
    int   n;
    n = 0;
    do begin
      @(negedge clk_in);
      rdy = hreadyout;
      data = hrdata;
      @(posedge clk_in);
      n++;
    end while (rdy !== 1'b1 && n < 50);
    if (rdy !== 1'b1) chk("hready wait", 32'h1, 32'h0);
  endtask : wait_ready

  // one single ahb-lite word transfer, entered just after a rising edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] data);
    logic [31:0] dummy;
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= wr;
    htrans <= 2'h2;
    wait_ready(dummy);
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready(data);
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask : bus

  task automatic pins_at_negedge(input logic [5:0] e_out, input logic [5:0] e_oe_b, input logic [5:0] mask);
    @(negedge clk_in);
    chk("pin_oe_b", {26'h0, e_oe_b & mask}, {26'h0, oe_b & mask});
    chk("pin_out", {26'h0, e_out & mask}, {26'h0, pin_o & mask});
    @(posedge clk_in);
  endtask : pins_at_negedge

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : final_report

  ////////////////////////////////////////////////////////////////////////////////
  // watchdog: the whole sequence needs well under 2000 cycles
  initial begin
    #(40 * 5000);
    n_errors++;
    final_report();
  end

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (6) @(posedge clk_in);
    rst_b_in <= 1'b1;
    @(negedge clk_in);
    chk("oe_b reset", 32'h3F, {26'h0, oe_b});
    chk("ibuf reset", 32'h2F, {26'h0, ibuf});
    chk("pull", 32'h0, {26'h0, pull});
    chk("drive", 32'h0, {26'h0, drv});
    @(posedge clk_in);
    bus(1'b0, 8'h00, 32'h0, rd);
    chk("data reset", 32'h0, rd);
    bus(1'b0, 8'h04, 32'h0, rd);
    chk("dir reset", 32'h0, rd);
    bus(1'b0, 8'h08, 32'h0, rd);
    chk("digital reset", 32'h0, rd);
    bus(1'b0, 8'h10, 32'h0, rd);
    chk("debug reset", 32'h1, rd);
    bus(1'b0, 8'h20, 32'h0, rd);
    chk("unmapped", 32'h0, rd);
    bus(1'b1, 8'h04, 32'hFFFFFFFF, rd);
    bus(1'b0, 8'h04, 32'h0, rd);
    chk("dir upper", 32'h0F, rd);
    // random traffic: data written before direction, board levels and debug drive random
    for (int k = 0; k < 24; k++) begin
      seed = next_rand(seed);
      d = seed[5:0];
      seed = next_rand(seed);
      dir = seed[3:0];
      alt_drv[4] <= seed[4];
      alt_data[4] <= seed[5];
      seed = next_rand(seed);
      ext <= seed[5:0];
      bus(1'b1, 8'h00, {26'h3FFFFFF, d}, rd);
      bus(1'b1, 8'h04, {28'h0, dir}, rd);
      bus(1'b0, 8'h00, 32'h0, rd);
      chk("data read", exp_read(d, dir, ext), rd);
      pins_at_negedge({1'b0, alt_data[4], d[3:0]}, {1'b1, ~alt_drv[4], ~dir}, {2'b01, dir | 4'hF});
    end
    // shared digital drives pin 0; direction still picks the latch for reads
    alt_drv <= 6'h01;
    alt_data <= 6'h00;
    ext <= 6'h3F;
    bus(1'b1, 8'h00, 32'h01, rd);
    bus(1'b1, 8'h04, 32'h01, rd);
    bus(1'b1, 8'h08, 32'h01, rd);
    pins_at_negedge(6'h00, 6'h00, 6'h01);
    bus(1'b0, 8'h00, 32'h0, rd);
    chk("digital read", 32'h01, rd & 32'h01);
    // analog on top of digital releases both buffers
    bus(1'b1, 8'h0C, 32'h01, rd);
    pins_at_negedge(6'h01, 6'h01, 6'h01);
    @(negedge clk_in);
    chk("ibuf analog", 32'h0, {31'h0, ibuf[0]});
    @(posedge clk_in);
    bus(1'b1, 8'h04, 32'h00, rd);
    bus(1'b0, 8'h00, 32'h0, rd);
    chk("analog input read", 32'h0, rd & 32'h01);
    bus(1'b1, 8'h0C, 32'h00, rd);
    bus(1'b1, 8'h08, 32'h00, rd);
    alt_drv <= 6'h00;
    // debug released: the output-only pin drives port data but still reads zero
    bus(1'b1, 8'h10, 32'h0, rd);
    bus(1'b1, 8'h00, 32'h10, rd);
    pins_at_negedge(6'h10, 6'h00, 6'h10);
    bus(1'b0, 8'h00, 32'h0, rd);
    chk("output-only read", 32'h0, rd & 32'h10);
    // wait then stop: pins hold while registers change, update on wakeup
    for (int m = 0; m < 2; m++) begin
      bus(1'b1, 8'h00, 32'h05, rd);
      bus(1'b1, 8'h04, 32'h0F, rd);
      if (m == 0) wait_mode <= 1'b1;
      else stop_mode <= 1'b1;
      repeat (2) @(posedge clk_in);
      bus(1'b1, 8'h00, 32'h0A, rd);
      bus(1'b1, 8'h04, 32'h03, rd);
      pins_at_negedge(6'h05, 6'h30, 6'h0F);
      bus(1'b0, 8'h14, 32'h0, rd);
      chk("status held", 32'h1, rd);
      wait_mode <= 1'b0;
      stop_mode <= 1'b0;
      repeat (2) @(posedge clk_in);
      pins_at_negedge(6'h0A, 6'h3C, 6'h0F);
    end
    final_report();
  end
endmodule : parallel_io_port_a_tb
